// ---- logic/asp_pkg.sv ----
// Constants shared by the sample pipeline port and its output buffer.
// Function
// - Strobe rise holds input, starts conversion.
// - Coarse five bits pick one of 32 taps.
// - Fine six bits: five low, one correction.
// - Decode aligns both results into one word.
// - Latched word appears two and half periods later.
// - Latches update on strobe fall, then delay.
// - Flag raised from one LSB past range.
// - Offset binary; over range gives all ones.
package asp_pkg;
  localparam int          WORD_W              = 10;
  localparam int          COARSE_W            = 5;
  localparam int          FINE_W              = 6;
  localparam int          LOW_W               = 5;
  localparam int          TAPS                = 32;
  localparam int          LEVEL_W             = 12;
  localparam int          CALC_W              = 13;
  // Input level that maps to the all-zeros word.
  localparam logic [12:0] LEVEL_BASE          = 13'h0400;
  localparam logic [12:0] LEVEL_SPAN          = 13'h03FF;
  localparam logic [9:0]  WORD_MIN            = 10'h000;
  localparam logic [9:0]  WORD_MAX            = 10'h3FF;
  // The fine flash sees the residue lifted by half a coarse step.
  localparam logic [12:0] FINE_HALF           = 13'h0010;
  localparam int          CLK_PERIOD_NS       = 10;
  localparam int          OUTPUT_UPDATE_DELAY_NS  = 12;
  localparam int          OUTPUT_UPDATE_DELAY_CYC =
    (OUTPUT_UPDATE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          BUF_DEPTH           = 2;
endpackage

// ---- logic/asp_word_buffer.sv ----
// Shift-style buffer whose head entry drives the outputs from flip-flops.
`timescale 1ns/100ps
module asp_word_buffer #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 2
) (
  input  wire logic             i_mclk,    // System clock.
  input  wire logic             i_reset_n, // Synchronous reset, active low.
  input  wire logic             i_valid,   // Entry offered.
  output logic                  o_ready,   // Room for one entry.
  input  wire logic [WIDTH-1:0] i_data,    // Offered entry.
  output logic                  o_valid,   // Head entry present.
  input  wire logic             i_ready,   // Receiver takes head.
  output logic      [WIDTH-1:0] o_data     // Head entry.
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] ONE = CW'(1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] slot [DEPTH];
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic [CW-1:0]    wr_idx;
  logic             push;
  logic             pop;

  // Ready ignores a same-cycle pop, so full stays honest and no path runs through.
  assign o_ready = (count != FULL);
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign wr_idx  = pop ? count - ONE : count;

  always_comb
  begin
    next_count = count;
    if (push && !pop)
    begin
      next_count = count + ONE;
    end
    else if (pop && !push)
    begin
      next_count = count - ONE;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      count   <= '0;
      o_valid <= 1'b0;
    end
    else
    begin
      count   <= next_count;
      o_valid <= (next_count != '0);
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        slot[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (push && wr_idx == CW'(i))
        begin
          slot[i] <= i_data;
        end
        else if (pop)
        begin
          slot[i] <= (i + 1 < DEPTH) ? slot[(i + 1) % DEPTH] : slot[i];
        end
      end
    end
  end

  assign o_data = slot[0];
endmodule // asp_word_buffer

// ---- logic/asp_sample_port.sv ----
// Sample strobe pipeline: hold, coarse, fine, decode, output latch and buffer.
`timescale 1ns/100ps
module asp_sample_port (
  input  wire logic        i_mclk,         // System clock, 100 MHz.
  input  wire logic        i_reset_n,      // Synchronous reset, active low.
  input  wire logic        i_strobe,       // Sample strobe pin, asynchronous.
  input  wire logic [11:0] i_level,        // Digitised input level, asynchronous.
  input  wire logic        i_word_ready,   // Receiver accepts the head word.
  output logic [9:0]       o_sample_word,  // Offset binary sample word.
  output logic             o_out_of_range, // Out-of-range flag for that word.
  output logic             o_word_valid,   // Head word present.
  output logic             o_overrun       // Pulse: latched word replaced unsent.
);
  logic        strobe_s1;
  logic        strobe_s2;
  logic        strobe_s3;
  logic [11:0] level_s1;
  logic [11:0] level_s2;
  logic        rise;
  logic        fall;

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      strobe_s1 <= 1'b0;
      strobe_s2 <= 1'b0;
      strobe_s3 <= 1'b0;
      level_s1  <= '0;
      level_s2  <= '0;
    end
    else
    begin
      strobe_s1 <= i_strobe;
      strobe_s2 <= strobe_s1;
      strobe_s3 <= strobe_s2;
      level_s1  <= i_level;
      level_s2  <= level_s1;
    end
  end

  // The strobe is assumed free running at a steady duty; stalls are not detected.
  assign rise = strobe_s2 && !strobe_s3;
  assign fall = !strobe_s2 && strobe_s3;

  function automatic logic [12:0] tap_level(input logic [31:0] onehot);
    logic [12:0] lvl;
    lvl = '0;
    for (int t = 0; t < asp_pkg::TAPS; t++)
    begin
      if (onehot[t])
      begin
        lvl = lvl | 13'(t << asp_pkg::LOW_W);
      end
    end
    return lvl;
  endfunction

  // Stage one: first hold.
  logic [11:0] hold_level;
  logic        hold_valid;

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      hold_level <= '0;
      hold_valid <= 1'b0;
    end
    else if (rise)
    begin
      hold_level <= level_s2;
      hold_valid <= 1'b1;
    end
  end

  // Stage two: range check, coarse flash and tap selection.
  logic [12:0] held_rel;
  logic        held_low;
  logic        held_high;
  logic [12:0] clamped;
  logic [4:0]  coarse;
  logic [31:0] tap_sel;
  logic [12:0] pipe_level;
  logic        conv_oor;
  logic        conv_valid;

  assign held_low  = {1'b0, hold_level} < asp_pkg::LEVEL_BASE;
  assign held_rel  = {1'b0, hold_level} - asp_pkg::LEVEL_BASE;
  assign held_high = !held_low && (held_rel > asp_pkg::LEVEL_SPAN);
  assign clamped   = held_low ? '0 : (held_high ? asp_pkg::LEVEL_SPAN : held_rel);

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      coarse     <= '0;
      tap_sel    <= 32'h00000001;
      pipe_level <= '0;
      conv_oor   <= 1'b0;
      conv_valid <= 1'b0;
    end
    else if (rise)
    begin
      coarse     <= clamped[9:5];
      tap_sel    <= 32'h00000001 << clamped[9:5];
      pipe_level <= clamped;
      conv_oor   <= held_low || held_high;
      conv_valid <= hold_valid;
    end
  end

  // Stage three: residue from the selected tap, fine flash and correction.
  logic [12:0] residue;
  logic [5:0]  fine;
  logic [12:0] merged;
  logic [9:0]  decoded;
  logic        dec_oor;
  logic        dec_valid;

  assign residue = pipe_level - tap_level(tap_sel);
  assign fine    = 6'(residue + asp_pkg::FINE_HALF);
  // The top fine bit carries into the coarse field, the low five fill the word.
  assign merged  = {3'h0, coarse, 5'h00} + {7'h00, fine} - asp_pkg::FINE_HALF;

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      decoded   <= '0;
      dec_oor   <= 1'b0;
      dec_valid <= 1'b0;
    end
    else if (rise)
    begin
      decoded   <= merged[9:0];
      dec_oor   <= conv_oor;
      dec_valid <= conv_valid;
    end
  end

  // Output latch on the fall after the third rise, so two and a half periods.
  logic [9:0]  latch_word;
  logic        latch_oor;
  logic        latch_pending;
  logic [1:0]  delay_cnt;
  logic        delay_done;
  logic        buf_ready;

  localparam logic [1:0] DELAY_LAST = 2'(asp_pkg::OUTPUT_UPDATE_DELAY_CYC - 1);

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      latch_word <= '0;
      latch_oor  <= 1'b0;
    end
    else if (fall && dec_valid)
    begin
      latch_word <= decoded;
      latch_oor  <= dec_oor;
    end
  end

  // The word is handed on only once the update delay has passed.
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      delay_cnt  <= '0;
      delay_done <= 1'b0;
    end
    else if (fall && dec_valid)
    begin
      delay_cnt  <= '0;
      delay_done <= 1'b0;
    end
    else if (latch_pending && !delay_done)
    begin
      delay_cnt  <= delay_cnt + 2'h1;
      delay_done <= (delay_cnt == DELAY_LAST);
    end
  end

  // A new fall while the buffer still refuses replaces the word and reports it.
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      latch_pending <= 1'b0;
      o_overrun     <= 1'b0;
    end
    else
    begin
      // A word that enters the buffer on this very edge is not lost, so it is not reported.
      o_overrun <= fall && dec_valid && latch_pending && !(delay_done && buf_ready);
      if (fall && dec_valid)
      begin
        latch_pending <= 1'b1;
      end
      else if (delay_done && buf_ready)
      begin
        latch_pending <= 1'b0;
      end
    end
  end

  asp_word_buffer #(
    .WIDTH (asp_pkg::WORD_W + 1),
    .DEPTH (asp_pkg::BUF_DEPTH)
  ) u_buffer (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_valid   (latch_pending && delay_done),
    .o_ready   (buf_ready),
    .i_data    ({latch_oor, latch_word}),
    .o_valid   (o_word_valid),
    .i_ready   (i_word_ready),
    .o_data    ({o_out_of_range, o_sample_word})
  );

  hold_capture_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    rise |=> (hold_level == $past(level_s2)))
    else $error("hold stage missed the strobe rise");

  tap_onehot_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $onehot(tap_sel) && tap_sel[coarse])
    else $error("tap select not one-hot on the coarse code");

  fine_window_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    conv_valid |-> (fine >= 6'h10) && (fine <= 6'h2F))
    else $error("fine result outside its correction window");

  decode_align_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (rise && conv_valid) |=> ({3'h0, decoded} == $past(pipe_level)))
    else $error("decoded word does not match its sample");

  latch_edge_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $changed(latch_word) |-> $past(fall))
    else $error("output latch changed off the strobe fall");

  latch_value_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (fall && dec_valid) |=> (latch_word == $past(decoded)))
    else $error("output latch did not take the decoded word");

  flag_range_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    rise |=> (conv_oor == ($past(held_low) || $past(held_high))))
    else $error("out-of-range flag wrong for held level");

  flag_word_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (latch_oor && latch_pending) |-> (latch_word == asp_pkg::WORD_MAX || latch_word == asp_pkg::WORD_MIN))
    else $error("out-of-range word is not at a full-scale end");

  flag_latency_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (fall && dec_valid) |=> (latch_oor == $past(dec_oor)))
    else $error("flag not latched with its word");

  update_delay_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (fall && dec_valid) |=> !delay_done ##1 !delay_done ##1 delay_done)
    else $error("word handed on at the wrong delay");
endmodule // asp_sample_port

// ---- testbench/asp_capture_model.sv ----
// Capture-side model: continuous sample strobe source and stalling word receiver.
`timescale 1ns/100ps
module asp_capture_model (
  input  wire logic       i_mclk,      // System clock.
  input  wire logic       i_en,        // Strobe runs while high.
  input  wire logic [7:0] i_half,      // Strobe half period in clocks.
  input  wire logic [1:0] i_mode,      // 0 ready, 1 one in three, 2 stalled.
  output logic            o_strobe,    // Sample strobe.
  output logic            o_word_ready // Takes the head word.
);
  logic [7:0] cnt;
  logic [1:0] phase;

  initial
  begin
    o_strobe     = 1'h0;
    o_word_ready = 1'h0;
    cnt          = 8'h01;
    phase        = 2'h0;
  end

  // Equal halves with no gaps; the strobe rests low only when the run is stopped.
  always @(posedge i_mclk)
  begin
    if (!i_en)
    begin
      o_strobe <= 1'h0;
      cnt      <= 8'h01;
    end
    else if (cnt >= i_half)
    begin
      o_strobe <= ~o_strobe;
      cnt      <= 8'h01;
    end
    else
      cnt <= cnt + 8'h01;
  end

  // Words are taken only on clock edges, long after the output update delay.
  always @(posedge i_mclk)
  begin
    phase        <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    o_word_ready <= (i_mode == 2'h0) || (i_mode == 2'h1 && phase == 2'h0);
  end
endmodule // asp_capture_model

// ---- testbench/adc_sample_pipeline_port_tb.sv ----
// Self-checking bench for the sample pipeline port.
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module adc_sample_pipeline_port_tb;
  logic        i_mclk = 1'h0;
  logic        i_reset_n = 1'h0;
  logic [11:0] i_level = 12'h400;
  logic        en = 1'h0;
  logic [7:0]  half = 8'h04;
  logic [1:0]  mode = 2'h0;
  logic        strobe, ready, ovr_seen;
  logic [9:0]  o_sample_word;
  logic        o_out_of_range, o_word_valid, o_overrun;
  logic [10:0] exp_cur = 11'h000;
  logic [11:0] got;
  logic [10:0] exp_q[$];
  int          err_total = 0, n_checks = 0, n_rise = 0, n_fall = 0, n_pop = 0;
  // Each row: input level, then the flag and word it should give.
  logic [22:0] rows[10] = '{{12'h400, 11'h000}, {12'h7FF, 11'h3FF}, {12'h600, 11'h200},
    {12'h3FF, 11'h400}, {12'h800, 11'h7FF}, {12'h000, 11'h400}, {12'hFFF, 11'h7FF},
    {12'h5FF, 11'h1FF}, {12'h41F, 11'h01F}, {12'h420, 11'h020}};

  always #5 i_mclk = ~i_mclk;

  asp_sample_port asp_sample_port_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_strobe(strobe),
    .i_level(i_level), .i_word_ready(ready), .o_sample_word(o_sample_word),
    .o_out_of_range(o_out_of_range), .o_word_valid(o_word_valid), .o_overrun(o_overrun));
  asp_capture_model asp_capture_model_inst (.i_mclk(i_mclk), .i_en(en), .i_half(half),
    .i_mode(mode), .o_strobe(strobe), .o_word_ready(ready));

  always @(posedge strobe)
  begin
    n_rise++;
    exp_q.push_back(exp_cur);
  end
  always @(negedge strobe) n_fall++;

  // Every word taken must match the oldest sample still owed, flag included.
  // Looked at half a clock before the popping edge, where the head word has settled.
  always @(negedge i_mclk)
    if (i_reset_n && o_word_valid && ready)
    begin
      got = (exp_q.size() > 0) ? {1'h0, exp_q.pop_front()} : 12'hFFF;
      n_pop++;
      `CHK({1'h0, o_out_of_range, o_sample_word}, got)
    end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  task automatic do_reset(input logic [11:0] lvl, input logic [10:0] ex);
    en        <= 1'h0;
    i_reset_n <= 1'h0;
    i_level   <= lvl;
    exp_cur   <= ex;
    cyc(4);
    `CHK({o_word_valid, o_overrun, o_out_of_range, o_sample_word}, 13'h0000)
    exp_q.delete();
    n_rise = 0;
    n_fall = 0;
    n_pop  = 0;
    i_reset_n <= 1'h1;
    cyc(1);
  endtask

  task automatic results;
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #100000;
    err_total++;
    results();
  end

  initial
  begin
    do_reset(12'h400, 11'h000);
    mode <= 2'h1;
    for (int i = 0; i < 10; i++)
    begin
      if (i > 0)
        @(negedge strobe);
      @(posedge i_mclk);
      i_level <= rows[i][22:11];
      exp_cur <= rows[i][10:0];
      en      <= 1'h1;
    end
    cyc(100);
    `CHK(n_pop >= 10, 1'h1)
    $display("table test done");

    // First word only after the third fall: two and a half periods from its rise.
    // At the slowest allowed rate the fourth rise comes before the word shows.
    do_reset(12'h555, 11'h155);
    mode <= 2'h0;
    half <= 8'h05;
    en   <= 1'h1;
    for (int k = 0; k < 200 && !o_word_valid; k++)
      cyc(1);
    `CHK({n_rise[3:0], n_fall[3:0]}, 8'h43)
    cyc(60);
    `CHK(n_pop > 2, 1'h1)
    $display("latency test done");

    // A stalled receiver fills the buffer; the head word must survive overruns.
    do_reset(12'h500, 11'h100);
    mode     <= 2'h2;
    half     <= 8'h04;
    en       <= 1'h1;
    ovr_seen = 1'h0;
    for (int k = 0; k < 300 && !ovr_seen; k++)
    begin
      cyc(1);
      ovr_seen = o_overrun;
    end
    `CHK(ovr_seen, 1'h1)
    `CHK({o_word_valid, o_out_of_range, o_sample_word}, 12'h900)
    mode <= 2'h0;
    cyc(50);
    `CHK(n_pop > 3, 1'h1)
    $display("overrun test done");
    results();
  end
endmodule // adc_sample_pipeline_port_tb
